// ==== shared/ivp_pkg.sv ====
/*
   Constants for the interrupt priority and vectoring block: register map,
   field positions, reset values and source layout.
   Assumes a 32-bit AHB-Lite bus with one word per register.
*/
package ivp_pkg;

   // ----------------------------------------------------------------------
   // Sizes
   // ----------------------------------------------------------------------
   localparam int NSRC      = 14;
   localparam int NTRAP     = 8;
   localparam int NPRIO_REG = 5;
   localparam int STACK_D   = 8;
   localparam int SP_W      = 4;
   localparam int TDIS_W    = 14;
   localparam int EVT_W     = 3;

   // ----------------------------------------------------------------------
   // Register byte addresses
   // ----------------------------------------------------------------------
   localparam logic [7:0] OFS_PRIO_CHARGE  = 8'h00;
   localparam logic [7:0] OFS_PRIO_SER3    = 8'h04;
   localparam logic [7:0] OFS_PRIO_SER4    = 8'h08;
   localparam logic [7:0] OFS_PRIO_SPI3    = 8'h0C;
   localparam logic [7:0] OFS_PRIO_CAPCMP9 = 8'h10;
   localparam logic [7:0] OFS_CTL_STATUS   = 8'h14;
   localparam logic [7:0] OFS_CTL_ONE      = 8'h18;
   localparam logic [7:0] OFS_CPU_LEVEL    = 8'h1C;
   localparam logic [7:0] OFS_EVT_STATUS   = 8'h20;
   localparam logic [7:0] OFS_EVT_ENABLE   = 8'h24;
   localparam logic [7:0] OFS_EVT_CLEAR    = 8'h28;
   localparam logic [7:0] OFS_TIMED_DIS    = 8'h2C;

   // ----------------------------------------------------------------------
   // Source layout: register index and field lsb, in vector order
   // ----------------------------------------------------------------------
   localparam int SRC_REG [NSRC] = '{0, 1, 1, 1, 2, 2, 2, 2, 3, 3, 3, 3, 4, 4};
   localparam int SRC_LSB [NSRC] = '{4, 12, 8, 4, 12, 8, 4, 0, 12, 8, 4, 0, 4, 0};
   // Vector number of source 0; the value is arbitrary
   localparam logic [7:0] SRC_VEC_BASE = 8'h60;
   localparam logic [7:0] VEC_BIAS     = 8'h08;

   // ----------------------------------------------------------------------
   // Fields and values
   // ----------------------------------------------------------------------
   localparam logic [2:0] PRIO_RST    = 3'h4;
   localparam logic [2:0] PRIO_OFF    = 3'h0;
   localparam logic [3:0] LVL_USR_MAX = 4'h7;
   localparam logic [3:0] LVL_TDIS    = 4'h6;
   localparam logic [3:0] LVL_TRAP0   = 4'h8;
   localparam int RQO_BIT   = 15;
   localparam int VCAP_BIT  = 13;
   localparam int LVL_LSB   = 8;
   localparam int NEST_BIT  = 15;
   localparam int EVT_ACK   = 0;
   localparam int EVT_RQO   = 1;
   localparam int EVT_STACK = 2;

endpackage

// ==== src/ivp_intc.sv ====
/*
   Interrupt priority and vectoring controller with AHB-Lite register slave.
   Assumes peripheral flags and trap requests arrive already enabled and on
   clk; the core answers irq_req with a one-cycle irq_ack and ends each
   service routine with a one-cycle irq_ret.
*/
module ivp_intc
   import ivp_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              rst,
   input  wire logic              hsel,
   input  wire logic [31:0]       haddr,
   input  wire logic [1:0]        htrans,
   input  wire logic              hwrite,
   input  wire logic [2:0]        hsize,
   input  wire logic [31:0]       hwdata,
   input  wire logic              hready,
   output logic                   hreadyout,
   output logic                   hresp,
   output logic [31:0]            hrdata,
   input  wire logic [NSRC-1:0]   src_flag,
   input  wire logic [NTRAP-1:0]  trap_req,
   input  wire logic              irq_ack,
   input  wire logic              irq_ret,
   output logic                   irq_req,
   output logic [7:0]             irq_vec,
   output logic [3:0]             irq_level,
   output logic [3:0]             new_cpu_level,
   output logic                   ctl_irq
);

   // ----------------------------------------------------------------------
   // State
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic [NSRC-1:0][2:0]    prio;
      logic                    vector_capture_cfg;
      logic                    nesting_disable;
      logic [STACK_D-1:0][3:0] stack;
      logic [SP_W-1:0]         sp;
      logic [3:0]              cur_level;
      logic [6:0]              last_vec;
      logic                    req;
      logic [7:0]              vec;
      logic [3:0]              level;
      logic [TDIS_W-1:0]       tdis_cnt;
      logic                    rqo_seen;
      logic [EVT_W-1:0]        evt_status;
      logic [EVT_W-1:0]        evt_enable;
      logic                    irq_out;
      logic                    ph_valid;
      logic                    ph_write;
      logic [7:0]              ph_addr;
      logic                    rd_wait;
      logic                    readyout;
      logic [31:0]             rdata;
   } ivp_state_t;

   ivp_state_t st;
   ivp_state_t next_st;

   // ----------------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------------
   // Packs one 16-bit priority register; gaps stay zero
   function automatic logic [15:0] prio_word(input logic [NSRC-1:0][2:0] p,
                                             input int r);
      logic [15:0] d;
      d = 16'h0000;
      for (int i = 0; i < NSRC; i++) begin
         if (SRC_REG[i] == r) begin
            d[SRC_LSB[i] +: 3] = p[i];
         end
      end
      return d;
   endfunction

   function automatic int prio_index(input logic [7:0] a);
      int r;
      r = -1;
      case (a)
         OFS_PRIO_CHARGE:  r = 0;
         OFS_PRIO_SER3:    r = 1;
         OFS_PRIO_SER4:    r = 2;
         OFS_PRIO_SPI3:    r = 3;
         OFS_PRIO_CAPCMP9: r = 4;
         default:          r = -1;
      endcase
      return r;
   endfunction

   // ----------------------------------------------------------------------
   // Per-source qualification
   // ----------------------------------------------------------------------
   // A zero priority gates the flag here, so the arbiter never sees it and
   // a flagged but switched-off source cannot win a tie either
   logic [NSRC-1:0] src_live;

   for (genvar g = 0; g < NSRC; g++) begin : g_live
      assign src_live[g] = src_flag[g] && st.prio[g] != PRIO_OFF;
   end

   // ----------------------------------------------------------------------
   // Arbitration and register logic
   // ----------------------------------------------------------------------
   logic [2:0]      best_p;
   logic [7:0]      best_vec;
   logic [3:0]      user_thr;
   logic            user_go;
   logic            trap_any;
   logic [3:0]      trap_lvl;
   logic            trap_go;
   logic            rqo;
   logic            take_ack;
   logic            bus_wr;
   logic [15:0]     status_word;
   logic [EVT_W-1:0] evt_set;
   int              ridx;

   always_comb begin
      next_st  = st;
      best_p   = PRIO_OFF;
      best_vec = SRC_VEC_BASE;
      trap_any = 1'b0;
      trap_lvl = LVL_TRAP0;
      evt_set  = '0;
      ridx     = -1;

      // Strict compare keeps the lowest index on a tie
      for (int i = 0; i < NSRC; i++) begin
         if (src_live[i] && st.prio[i] > best_p) begin
            best_p   = st.prio[i];
            best_vec = SRC_VEC_BASE + 8'(i);
         end
      end

      // User masking threshold from CPU level, timed disable and nesting
      user_thr = st.cur_level;
      if (st.tdis_cnt != '0 && user_thr < LVL_TDIS) begin
         user_thr = LVL_TDIS;
      end
      if (st.nesting_disable && st.sp != '0 && user_thr < LVL_USR_MAX) begin
         user_thr = LVL_USR_MAX;
      end
      user_go = best_p != PRIO_OFF && {1'b0, best_p} > user_thr;
      rqo     = best_p != PRIO_OFF && !user_go;

      // Traps compare only against the running level
      for (int t = 0; t < NTRAP; t++) begin
         if (trap_req[t]) begin
            trap_any = 1'b1;
            trap_lvl = LVL_TRAP0 + 4'(t);
         end
      end
      trap_go = trap_any && trap_lvl > st.cur_level;

      // Request is rebuilt every cycle and is low in the cycle after an acknowledge
      take_ack = irq_ack && st.req;
      next_st.req = (trap_go || user_go) && !take_ack;
      if (trap_go) begin
         next_st.level = trap_lvl;
         next_st.vec   = 8'h00;
      end else if (user_go) begin
         next_st.level = {1'b0, best_p};
         next_st.vec   = best_vec;
      end

      // Acknowledge pushes the old level; return pops it
      if (take_ack) begin
         evt_set[EVT_ACK] = 1'b1;
         next_st.cur_level = st.level;
         if (st.level < LVL_TRAP0) begin
            next_st.last_vec = 7'(st.vec - VEC_BIAS);
         end
         if (st.sp == SP_W'(STACK_D)) begin
            evt_set[EVT_STACK] = 1'b1;
         end else begin
            next_st.stack[st.sp[2:0]] = st.cur_level;
            next_st.sp = st.sp + 1'b1;
         end
      end else if (irq_ret) begin
         if (st.sp == '0) begin
            evt_set[EVT_STACK] = 1'b1;
         end else begin
            next_st.sp        = st.sp - 1'b1;
            next_st.cur_level = st.stack[3'(st.sp - 1'b1)];
         end
      end

      if (st.tdis_cnt != '0) begin
         next_st.tdis_cnt = st.tdis_cnt - 1'b1;
      end

      next_st.rqo_seen = rqo;
      if (rqo && !st.rqo_seen) begin
         evt_set[EVT_RQO] = 1'b1;
      end

      // Status word
      status_word = 16'h0000;
      status_word[RQO_BIT]  = rqo;
      status_word[VCAP_BIT] = st.vector_capture_cfg;
      status_word[LVL_LSB +: 4] = st.cur_level;
      if (st.vector_capture_cfg) begin
         status_word[6:0] = 7'(best_vec - VEC_BIAS);
      end else begin
         status_word[6:0] = st.last_vec;
      end

      // Bus: address phase, then data phase
      bus_wr = st.ph_valid && st.ph_write;
      next_st.readyout = 1'b1;
      next_st.rd_wait  = 1'b0;
      if (hsel && hready && htrans[1]) begin
         next_st.ph_valid = 1'b1;
         next_st.ph_write = hwrite;
         next_st.ph_addr  = haddr[7:0];
         if (!hwrite) begin
            next_st.readyout = 1'b0;
            next_st.rd_wait  = 1'b1;
         end
      end else if (st.readyout) begin
         next_st.ph_valid = 1'b0;
      end

      if (bus_wr) begin
         ridx = prio_index(st.ph_addr);
         if (ridx >= 0) begin
            for (int i = 0; i < NSRC; i++) begin
               if (SRC_REG[i] == ridx) begin
                  next_st.prio[i] = hwdata[SRC_LSB[i] +: 3];
               end
            end
         end
         case (st.ph_addr)
            OFS_CTL_STATUS: next_st.vector_capture_cfg = hwdata[VCAP_BIT];
            OFS_CTL_ONE:    next_st.nesting_disable    = hwdata[NEST_BIT];
            OFS_CPU_LEVEL: begin
               if (st.cur_level < LVL_TRAP0) begin
                  next_st.cur_level = {1'b0, hwdata[2:0]};
               end
            end
            OFS_EVT_ENABLE: next_st.evt_enable = hwdata[EVT_W-1:0];
            OFS_EVT_CLEAR:  next_st.evt_status = st.evt_status & ~hwdata[EVT_W-1:0];
            OFS_TIMED_DIS:  next_st.tdis_cnt   = hwdata[TDIS_W-1:0];
            default: ;
         endcase
      end
      // Set wins over a clear in the same cycle
      next_st.evt_status = next_st.evt_status | evt_set;
      next_st.irq_out    = |(next_st.evt_status & next_st.evt_enable);

      if (st.rd_wait) begin
         next_st.ph_valid = 1'b0;
         next_st.rdata    = 32'h0000_0000;
         ridx = prio_index(st.ph_addr);
         if (ridx >= 0) begin
            next_st.rdata[15:0] = prio_word(st.prio, ridx);
         end
         case (st.ph_addr)
            OFS_CTL_STATUS: next_st.rdata[15:0] = status_word;
            OFS_CTL_ONE:    next_st.rdata[NEST_BIT] = st.nesting_disable;
            OFS_CPU_LEVEL:  next_st.rdata[3:0] = st.cur_level;
            OFS_EVT_STATUS: next_st.rdata[EVT_W-1:0] = st.evt_status;
            OFS_EVT_ENABLE: next_st.rdata[EVT_W-1:0] = st.evt_enable;
            OFS_TIMED_DIS:  next_st.rdata[TDIS_W-1:0] = st.tdis_cnt;
            default: ;
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         st <= '0;
         for (int i = 0; i < NSRC; i++) begin
            st.prio[i] <= PRIO_RST;
         end
         st.readyout <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   assign hreadyout     = st.readyout;
   assign hresp         = 1'b0;
   assign hrdata        = st.rdata;
   assign irq_req       = st.req;
   assign irq_vec       = st.vec;
   assign irq_level     = st.level;
   assign new_cpu_level = st.cur_level;
   assign ctl_irq       = st.irq_out;

endmodule

// ==== sim/ivp_checker.sv ====
/*
   Port-level assertions for the interrupt priority controller.
   Assumes one clock domain, synchronous reset, and is bound at the foot.
*/
module ivp_checker
   import ivp_pkg::*;
(
   input wire logic              clk,
   input wire logic              rst,
   input wire logic              hsel,
   input wire logic [1:0]        htrans,
   input wire logic              hwrite,
   input wire logic              hready,
   input wire logic              hreadyout,
   input wire logic              hresp,
   input wire logic [31:0]       hrdata,
   input wire logic [NTRAP-1:0]  trap_req,
   input wire logic              irq_ack,
   input wire logic              irq_req,
   input wire logic [7:0]        irq_vec,
   input wire logic [3:0]        irq_level,
   input wire logic [3:0]        new_cpu_level
);
   timeunit 1ns;
   timeprecision 100ps;

   default clocking @(posedge clk); endclocking
   default disable iff (rst);

   // ----------------------------------------------------------------
   // Bus and core handshakes
   // ----------------------------------------------------------------
   bus_wait_a: assert property (hsel && hready && htrans[1] && !hwrite |=> !hreadyout ##1 hreadyout)
      else $error("read wait state wrong");
   hi_zero_a: assert property ($rose(hreadyout) |-> hrdata[31:16] == 16'h0)
      else $error("upper read bits not zero");
   resp_okay_a: assert property (hresp == 1'b0)
      else $error("error response seen");
   // A level change needs one cycle to reach the request flop
   req_above_a: assert property (irq_req && $stable(new_cpu_level) |-> irq_level > new_cpu_level)
      else $error("request not above cpu level");
   ack_drop_a: assert property (irq_req && irq_ack |=> !irq_req)
      else $error("request held after ack");
   ack_level_a: assert property (irq_req && irq_ack |=> new_cpu_level == $past(irq_level))
      else $error("cpu level not taken from ack");
   trap_pass_a: assert property (trap_req[0] && !irq_ack && new_cpu_level < LVL_TRAP0 |=> irq_req)
      else $error("trap not forwarded");
   trap_vec_a: assert property (irq_req && irq_level >= LVL_TRAP0 |-> irq_vec == 8'h00)
      else $error("trap vector wrong");
   user_vec_a: assert property (irq_req && irq_level < LVL_TRAP0 |-> irq_vec >= SRC_VEC_BASE && irq_vec < SRC_VEC_BASE + 8'(NSRC))
      else $error("user vector out of range");
endmodule

bind ivp_intc ivp_checker chk (.clk, .rst, .hsel, .htrans, .hwrite, .hready, .hreadyout, .hresp,
   .hrdata, .trap_req, .irq_ack, .irq_req, .irq_vec, .irq_level, .new_cpu_level);

// ==== sim/ivp_core_model.sv ====
/*
   Core model: acknowledges a held request after a set delay and
   returns from the routine one cycle after the bench asks for it.
   Assumes the block's clock and synchronous reset.
*/
module ivp_core_model (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        irq_req,
   input  wire logic        ack_en,
   input  wire logic [3:0]  ack_dly,
   input  wire logic        ret_cmd,
   output logic             irq_ack,
   output logic             irq_ret
);
   timeunit 1ns;
   timeprecision 100ps;

   logic [3:0] cnt;

   // Ack only while the request is seen, so a slow core can miss it
   always_ff @(posedge clk) begin
      if (rst) begin
         cnt     <= 4'h0;
         irq_ack <= 1'b0;
         irq_ret <= 1'b0;
      end else begin
         irq_ack <= 1'b0;
         irq_ret <= ret_cmd;
         cnt     <= 4'h0;
         if (irq_req && ack_en && !irq_ack) begin
            if (cnt == ack_dly) begin
               irq_ack <= 1'b1;
            end else begin
               cnt <= cnt + 4'h1;
            end
         end
      end
   end
endmodule

// ==== sim/ivp_intc_tb.sv ====
/*
   Self-checking bench for the interrupt priority controller.
   Assumes a 40 MHz clock and the core model on the far side.
*/
module ivp_intc_tb
   import ivp_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;

   logic             clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
   logic             ack_en = 1'b0, ret_cmd = 1'b0, irq_ack, irq_ret, irq_req;
   logic             hreadyout, hresp, ctl_irq;
   logic [31:0]      haddr = 32'h0, hwdata = 32'h0, hrdata;
   logic [1:0]       htrans = 2'h0;
   logic [NSRC-1:0]  src_flag = '0;
   logic [NTRAP-1:0] trap_req = '0;
   logic [7:0]       irq_vec;
   logic [3:0]       irq_level, new_cpu_level, ack_dly = 4'h0;
   int               bad_count = 0, samples_checked = 0;

   ivp_intc dut (.clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
      .hready(hreadyout), .hreadyout, .hresp, .hrdata, .src_flag, .trap_req, .irq_ack,
      .irq_ret, .irq_req, .irq_vec, .irq_level, .new_cpu_level, .ctl_irq);
   ivp_core_model core (.clk, .rst, .irq_req, .ack_en, .ack_dly, .ret_cmd, .irq_ack, .irq_ret);

   initial begin
      forever #12.5 clk = ~clk;
   end

   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic conclude;
      $display("compared %0d, bad %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wait_on(ref logic s, input logic v);
      int n;
      n = 0;
      @(posedge clk);
      while (s !== v) begin
         n++;
         if (n > 400) begin
            bad_count++;
            conclude();
         end
         @(posedge clk);
      end
   endtask

   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      hsel   <= 1'b1;
      haddr  <= {24'h0, a};
      hwrite <= w;
      htrans <= 2'h2;
      wait_on(hreadyout, 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      wait_on(hreadyout, 1'b1);
      q = hrdata;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      chk(q & m, e);
   endtask

   task automatic ret_pulse;
      ret_cmd <= 1'b1;
      @(posedge clk);
      ret_cmd <= 1'b0;
      repeat (3) @(posedge clk);
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_reset;
      logic [31:0] rv [5] = '{32'h40, 32'h4440, 32'h4444, 32'h4444, 32'h44};
      logic [31:0] rm [5] = '{32'h70, 32'h7770, 32'h7777, 32'h7777, 32'h77};
      for (int i = 0; i < 5; i++) begin
         rd(8'(4 * i), '1, rv[i]);
         wr(8'(4 * i), 32'hFFFF_FFFF);
         rd(8'(4 * i), '1, rm[i]);
         wr(8'(4 * i), 32'h0);
      end
      wr(OFS_CTL_STATUS, 32'hFFFF_FFFF);
      rd(OFS_CTL_STATUS, 32'hFFFF_7F80, 32'h2000);
      wr(OFS_CTL_STATUS, 32'h0);
      rd(8'h30, '1, 32'h0);
   endtask

   task automatic t_levels;
      src_flag <= 14'h1;
      for (int p = 1; p < 8; p++) begin
         wr(OFS_PRIO_CHARGE, 32'(p << 4));
         repeat (2) @(posedge clk);
         chk(irq_level, 32'(p));
      end
      wr(OFS_PRIO_CHARGE, 32'h0);
      repeat (3) @(posedge clk);
      chk(irq_req, 32'h0);
   endtask

   task automatic t_order;
      wr(OFS_PRIO_SER3, 32'h0350);
      wr(OFS_PRIO_SPI3, 32'h5000);
      src_flag <= 14'h10C;
      wait_on(irq_req, 1'b1);
      chk(irq_vec, SRC_VEC_BASE + 8'h3);
      ack_en <= 1'b1;
      wait_on(irq_ack, 1'b1);
      ack_en <= 1'b0;
      repeat (2) @(posedge clk);
      chk(new_cpu_level, 32'h5);
      chk(irq_req, 32'h0);
      rd(OFS_CTL_STATUS, 32'hFFFF, 32'h855B);
      wr(OFS_CTL_STATUS, 32'h2000);
      src_flag <= 14'h104;
      rd(OFS_CTL_STATUS, 32'hFFFF, 32'hA560);
      ret_pulse();
      chk(new_cpu_level, 32'h0);
      wait_on(irq_req, 1'b1);
      chk(irq_vec, SRC_VEC_BASE + 8'h8);
      src_flag <= '0;
      wr(OFS_CTL_STATUS, 32'h0);
      wr(OFS_PRIO_SER3, 32'h0);
   endtask

   task automatic t_mask;
      ack_dly <= 4'h3;
      wr(OFS_PRIO_CHARGE, 32'h70);
      wr(OFS_CPU_LEVEL, 32'h7);
      src_flag <= 14'h1;
      repeat (4) @(posedge clk);
      chk(irq_req, 32'h0);
      trap_req <= 8'h1;
      wait_on(irq_req, 1'b1);
      chk(irq_level, 32'h8);
      ack_en <= 1'b1;
      wait_on(irq_ack, 1'b1);
      ack_en <= 1'b0;
      trap_req <= '0;
      ret_pulse();
      chk(new_cpu_level, 32'h7);
      wr(OFS_CPU_LEVEL, 32'h0);
   endtask

   task automatic t_disable;
      wr(OFS_PRIO_SER3, 32'h0060);
      wr(OFS_TIMED_DIS, 32'h3C);
      repeat (3) @(posedge clk);
      chk(irq_req, 32'h1);
      chk(irq_level, 32'h7);
      src_flag <= 14'h8;
      repeat (4) @(posedge clk);
      chk(irq_req, 32'h0);
      wait_on(irq_req, 1'b1);
      chk(irq_level, 32'h6);
      src_flag <= '0;
   endtask

   task automatic t_nest;
      wr(OFS_CTL_ONE, 32'h8000);
      rd(OFS_CTL_ONE, '1, 32'h8000);
      wr(OFS_PRIO_SER3, 32'h0030);
      wr(OFS_PRIO_SPI3, 32'h5000);
      src_flag <= 14'h8;
      wait_on(irq_req, 1'b1);
      chk(irq_level, 32'h3);
      ack_en <= 1'b1;
      wait_on(irq_ack, 1'b1);
      ack_en <= 1'b0;
      src_flag <= 14'h100;
      repeat (4) @(posedge clk);
      chk(irq_req, 32'h0);
      ret_pulse();
      chk(irq_req, 32'h1);
      chk(irq_level, 32'h5);
      src_flag <= '0;
      wr(OFS_CTL_ONE, 32'h0);
   endtask

   task automatic t_events;
      rd(OFS_EVT_STATUS, 32'h1, 32'h1);
      chk(ctl_irq, 32'h0);
      // Return with an empty stack must flag the underflow event
      ret_pulse();
      rd(OFS_EVT_STATUS, '1, 32'h7);
      wr(OFS_EVT_ENABLE, 32'h1);
      repeat (2) @(posedge clk);
      chk(ctl_irq, 32'h1);
      wr(OFS_EVT_CLEAR, 32'h7);
      repeat (2) @(posedge clk);
      chk(ctl_irq, 32'h0);
      rd(OFS_EVT_STATUS, '1, 32'h0);
   endtask

   initial begin
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      t_levels();
      t_order();
      t_mask();
      t_disable();
      t_nest();
      t_events();
      conclude();
   end
endmodule
